// file: common/user_break_pkg.sv
// constants, types and enumerations for the user breakpoint and profiling block
package user_break_pkg;
    localparam int PC_W = 24;
    localparam int CTL_W = 32;
    localparam int CNT_W = 32;
    localparam int ADDR_DATA_W = 32;
    localparam int ADDR_IDX_W = 4;
    localparam int GROUPS = 4;
    localparam int INSN_W = 48;
    localparam int IR_W = 4;
    localparam int OWNER_BIT = 25;
    localparam int GRP_EN_LSB = 0;
    localparam int AND_COMBINE_BIT = 4;
    localparam int SINGLE_STEP_BIT = 8;
    localparam int BOOT_WORDS = 256;
    localparam int BOOT_CNT_W = 9;
    localparam logic [CTL_W-1:0] CTL_RESET = 32'h0000_0000;
    localparam logic [CNT_W-1:0] CNT_RESET = 32'h0000_0000;
    localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
    localparam logic [IR_W-1:0] IR_PC_SAMPLE = 4'h2;
    localparam logic [IR_W-1:0] IR_EMU_INSN = 4'h3;
    localparam logic [IR_W-1:0] IR_BRK_CTL = 4'h4;
    localparam logic [IR_W-1:0] IR_BYPASS = 4'hF;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } jtag_in_s;

    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
        TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR,
        TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
    } tap_state_e;

    typedef enum logic [1:0] {
        EXEC_RUN, EXEC_HALT, EXEC_STEP
    } exec_state_e;

    typedef enum logic [1:0] {
        SRC_MEMORY, SRC_BOOT, SRC_EMU_REG, SRC_CACHE
    } fetch_src_e;
endpackage

// file: hw/user_breakpoint_and_profiling.sv
// tap-side pc sampling, user breakpoint control, single step and fetch source selection
// Operation
// - a 24-bit shift register captures the program counter for emulator sampling.
// - in run-test/idle the sample register reloads the pc every core clock.
// - the pc sample register has no memory-mapped path, only tap shifting.
// - emulator owns breakpoints after reset; software takes them via bit 25.
// - with the owner bit clear the tap programs breakpoint control; software only with a write that sets bit 25.
// - with the owner bit set software may write every address range register.
// - software reaches the status register only while the owner bit is set.
// - status shows the hit source and clears on return from interrupt, except for a hit in that same cycle.
// - during single stepping user breakpoint hits leave status unchanged.
// - qualified user breakpoint events raise the low-priority breakpoint interrupt only while the owner bit is set.
// - with single step set, one instruction runs, then an emulator interrupt.
// - with single step set, a return in emulation space causes exactly one further instruction.
// - each single-stepped instruction flushes the pipeline on user-space re-entry.
// - during boot loading the pipeline gets idle until the boot interrupt.
// - in single step the pipeline stops; instructions come from a tap register.
// - on a cache hit the instruction comes from the cache, not memory.
// - each event decrements a nonzero counter unless software writes the counter in that cycle; interrupt only when counter is zero.
`timescale 1ns/1ns
`default_nettype none
module user_breakpoint_and_profiling
    import user_break_pkg::*;
#(
    parameter logic [INSN_W-1:0] IDLE_OPCODE = 48'h0000_0000_0000
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire jtag_in_s i_jtag,
    output logic o_tdo,
    input wire logic [PC_W-1:0] i_pc,
    input wire logic i_sw_ctl_wr,
    input wire logic [CTL_W-1:0] i_sw_ctl_data,
    input wire logic i_sw_cnt_wr,
    input wire logic [CNT_W-1:0] i_sw_cnt_data,
    input wire logic i_sw_addr_wr,
    input wire logic [ADDR_IDX_W-1:0] i_sw_addr_idx,
    input wire logic [ADDR_DATA_W-1:0] i_sw_addr_data,
    input wire logic i_sw_status_rd,
    input wire logic [GROUPS-1:0] i_group_hit,
    input wire logic i_insn_retired,
    input wire logic i_rti_exit,
    input wire logic i_boot_start,
    input wire logic i_boot_word,
    input wire logic i_boot_irq,
    input wire logic i_cache_hit,
    input wire logic [INSN_W-1:0] i_cache_insn,
    input wire logic [INSN_W-1:0] i_mem_insn,
    output logic [CTL_W-1:0] o_breakpoint_control,
    output logic o_user_break_owner_bit,
    output logic o_addr_we,
    output logic [ADDR_IDX_W-1:0] o_addr_idx,
    output logic [ADDR_DATA_W-1:0] o_addr_data,
    output logic o_status_rd_valid,
    output logic o_status_rd_denied,
    output logic [GROUPS-1:0] o_status_rd_data,
    output logic [CNT_W-1:0] o_event_count,
    output logic o_user_breakpoint_irq,
    output logic o_emulator_irq,
    output logic o_emu_space,
    output logic o_pipe_flush,
    output logic o_pipe_active,
    output fetch_src_e o_fetch_src,
    output logic [INSN_W-1:0] o_insn,
    output logic o_boot_loaded
);
    initial begin
        if (GROUPS > AND_COMBINE_BIT || OWNER_BIT >= CTL_W || BOOT_WORDS >= (1 << BOOT_CNT_W))
            $error("user_breakpoint_and_profiling: field layout does not fit");
    end

    // jtag pins: two-stage synchroniser, then edge detect on the settled copy
    jtag_in_s sync1_reg, sync2_reg;
    logic tck_prev_reg;
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            tck_prev_reg <= 1'b0;
        end else begin
            sync1_reg <= i_jtag;
            sync2_reg <= sync1_reg;
            tck_prev_reg <= sync2_reg.tck;
        end
    end
    logic tck_rise, tck_fall;
    assign tck_rise = sync2_reg.tck & ~tck_prev_reg;
    assign tck_fall = ~sync2_reg.tck & tck_prev_reg;

    // tap controller and data registers
    tap_state_e tap_reg, tap_next;
    logic [IR_W-1:0] ir_reg, ir_next, ir_shift_reg, ir_shift_next;
    logic [PC_W-1:0] pc_sample_shift_reg, pc_sample_shift_next;
    logic [INSN_W-1:0] dr_reg, dr_next, emu_insn_reg, emu_insn_next;
    logic tdo_reg, tdo_next, tap_ctl_upd_reg, tap_ctl_upd_next;
    logic [CTL_W-1:0] tap_ctl_word_reg, tap_ctl_word_next;

    always_comb begin
        tap_next = tap_reg;
        case (tap_reg)
            TAP_RESET: tap_next = sync2_reg.tms ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: tap_next = sync2_reg.tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: tap_next = sync2_reg.tms ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: tap_next = sync2_reg.tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: tap_next = sync2_reg.tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: tap_next = sync2_reg.tms ? TAP_UPD_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR: tap_next = sync2_reg.tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: tap_next = sync2_reg.tms ? TAP_UPD_DR : TAP_SHIFT_DR;
            TAP_UPD_DR: tap_next = sync2_reg.tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: tap_next = sync2_reg.tms ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR: tap_next = sync2_reg.tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: tap_next = sync2_reg.tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: tap_next = sync2_reg.tms ? TAP_UPD_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR: tap_next = sync2_reg.tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: tap_next = sync2_reg.tms ? TAP_UPD_IR : TAP_SHIFT_IR;
            TAP_UPD_IR: tap_next = sync2_reg.tms ? TAP_SEL_DR : TAP_IDLE;
            default: tap_next = TAP_RESET;
        endcase
        if (!tck_rise) begin
            tap_next = tap_reg;
        end
    end

    always_comb begin
        ir_next = ir_reg;
        ir_shift_next = ir_shift_reg;
        dr_next = dr_reg;
        emu_insn_next = emu_insn_reg;
        tap_ctl_word_next = tap_ctl_word_reg;
        tap_ctl_upd_next = 1'b0;
        tdo_next = tdo_reg;
        pc_sample_shift_next = pc_sample_shift_reg;
        // the sample follows the pc on core clocks, not tck edges
        if (tap_reg == TAP_IDLE) begin
            pc_sample_shift_next = i_pc;
        end
        if (tck_rise) begin
            case (tap_reg)
                TAP_RESET: ir_next = IR_BYPASS;
                TAP_CAP_IR: ir_shift_next = IR_CAPTURE;
                TAP_SHIFT_IR: ir_shift_next = {sync2_reg.tdi, ir_shift_reg[IR_W-1:1]};
                TAP_UPD_IR: ir_next = ir_shift_reg;
                TAP_CAP_DR: dr_next = '0;
                TAP_SHIFT_DR: begin
                    // the pc sample leaves only through this shift path
                    case (ir_reg)
                        IR_PC_SAMPLE: pc_sample_shift_next =
                            {sync2_reg.tdi, pc_sample_shift_reg[PC_W-1:1]};
                        IR_EMU_INSN: dr_next = {sync2_reg.tdi, dr_reg[INSN_W-1:1]};
                        IR_BRK_CTL: dr_next[CTL_W-1:0] = {sync2_reg.tdi, dr_reg[CTL_W-1:1]};
                        default: dr_next[0] = sync2_reg.tdi;
                    endcase
                end
                TAP_UPD_DR: begin
                    if (ir_reg == IR_EMU_INSN) begin
                        emu_insn_next = dr_reg;
                    end
                    if (ir_reg == IR_BRK_CTL) begin
                        tap_ctl_word_next = dr_reg[CTL_W-1:0];
                        tap_ctl_upd_next = 1'b1;
                    end
                end
                default: ;
            endcase
        end
        if (tck_fall) begin
            case (tap_reg)
                TAP_SHIFT_IR: tdo_next = ir_shift_reg[0];
                TAP_SHIFT_DR: tdo_next = (ir_reg == IR_PC_SAMPLE) ? pc_sample_shift_reg[0]
                                                                   : dr_reg[0];
                default: tdo_next = 1'b0;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            tap_reg <= TAP_RESET;
            ir_reg <= IR_BYPASS;
            ir_shift_reg <= '0;
            dr_reg <= '0;
            emu_insn_reg <= '0;
            tap_ctl_word_reg <= CTL_RESET;
            tap_ctl_upd_reg <= 1'b0;
            tdo_reg <= 1'b0;
            pc_sample_shift_reg <= '0;
        end else begin
            tap_reg <= tap_next;
            ir_reg <= ir_next;
            ir_shift_reg <= ir_shift_next;
            dr_reg <= dr_next;
            emu_insn_reg <= emu_insn_next;
            tap_ctl_word_reg <= tap_ctl_word_next;
            tap_ctl_upd_reg <= tap_ctl_upd_next;
            tdo_reg <= tdo_next;
            pc_sample_shift_reg <= pc_sample_shift_next;
        end
    end
    assign o_tdo = tdo_reg;

    // breakpoint control, event counting and status
    logic [CTL_W-1:0] breakpoint_control_reg, breakpoint_control_next;
    logic single_step_reg, single_step_next;
    logic [CNT_W-1:0] breakpoint_event_counter, counter_next;
    logic [GROUPS-1:0] breakpoint_hit_status_reg, status_next;
    logic [GROUPS-1:0] grp_en, grp_hits;
    logic owner, bp_event, fire, user_irq_reg, user_irq_next;
    logic addr_we_reg, addr_we_next, st_valid_reg, st_valid_next, st_denied_reg, st_denied_next;
    logic [ADDR_IDX_W-1:0] addr_idx_reg, addr_idx_next;
    logic [ADDR_DATA_W-1:0] addr_data_reg, addr_data_next;
    logic [GROUPS-1:0] st_data_reg, st_data_next;
    exec_state_e exec_reg, exec_next;

    assign owner = breakpoint_control_reg[OWNER_BIT];
    assign grp_en = breakpoint_control_reg[GRP_EN_LSB +: GROUPS];
    assign grp_hits = i_group_hit & grp_en;
    // and-combining needs at least one enabled group, else it would fire on nothing
    assign bp_event = (exec_reg != EXEC_HALT) &&
                      (breakpoint_control_reg[AND_COMBINE_BIT]
                          ? ((grp_en != '0) && (grp_hits == grp_en)) : (grp_hits != '0));
    assign fire = bp_event && (breakpoint_event_counter == '0);

    always_comb begin
        breakpoint_control_next = breakpoint_control_reg;
        single_step_next = single_step_reg;
        counter_next = breakpoint_event_counter;
        status_next = breakpoint_hit_status_reg;
        user_irq_next = 1'b0;
        addr_we_next = 1'b0;
        addr_idx_next = addr_idx_reg;
        addr_data_next = addr_data_reg;
        st_valid_next = 1'b0;
        st_denied_next = 1'b0;
        st_data_next = st_data_reg;
        if (tap_ctl_upd_reg) begin
            single_step_next = tap_ctl_word_reg[SINGLE_STEP_BIT];
            if (!owner) begin
                breakpoint_control_next = tap_ctl_word_reg;
            end
        end
        // software may always claim ownership; other writes need it already
        if (i_sw_ctl_wr && (owner || i_sw_ctl_data[OWNER_BIT])) begin
            breakpoint_control_next = i_sw_ctl_data;
        end
        if (i_sw_addr_wr && owner) begin
            addr_we_next = 1'b1;
            addr_idx_next = i_sw_addr_idx;
            addr_data_next = i_sw_addr_data;
        end
        if (i_sw_status_rd) begin
            st_valid_next = owner;
            st_denied_next = !owner;
            st_data_next = owner ? breakpoint_hit_status_reg : '0;
        end
        if (i_sw_cnt_wr && owner) begin
            counter_next = i_sw_cnt_data;
        end else if (bp_event && breakpoint_event_counter != '0) begin
            counter_next = breakpoint_event_counter - 1'b1;
        end
        if (i_rti_exit) begin
            status_next = '0;
        end
        if (fire && owner) begin
            user_irq_next = 1'b1;
            // a hit in the clearing cycle survives the return
            if (!single_step_reg) begin
                status_next = status_next | grp_hits;
            end
        end
    end

    // execution space: run, halted in emulation space, or stepping one instruction
    logic emu_irq_reg, emu_irq_next, flush_reg, flush_next;
    always_comb begin
        exec_next = exec_reg;
        emu_irq_next = 1'b0;
        flush_next = 1'b0;
        case (exec_reg)
            EXEC_RUN: begin
                if (fire && !owner) begin
                    exec_next = EXEC_HALT;
                    emu_irq_next = 1'b1;
                end
            end
            EXEC_HALT: begin
                if (i_rti_exit) begin
                    exec_next = single_step_reg ? EXEC_STEP : EXEC_RUN;
                    flush_next = single_step_reg;
                end
            end
            EXEC_STEP: begin
                if (i_insn_retired) begin
                    exec_next = EXEC_HALT;
                    emu_irq_next = 1'b1;
                end
            end
            default: exec_next = EXEC_RUN;
        endcase
    end

    // fetch source: emulation register beats boot, boot beats cache, cache beats memory
    logic boot_active_reg, boot_active_next, boot_loaded_reg, boot_loaded_next;
    logic [BOOT_CNT_W-1:0] boot_cnt_reg, boot_cnt_next;
    fetch_src_e src_reg, src_next;
    logic [INSN_W-1:0] insn_reg, insn_next;
    always_comb begin
        boot_active_next = boot_active_reg;
        boot_cnt_next = boot_cnt_reg;
        boot_loaded_next = boot_loaded_reg;
        if (i_boot_start) begin
            boot_active_next = 1'b1;
            boot_cnt_next = '0;
            boot_loaded_next = 1'b0;
        end else if (boot_active_reg && i_boot_word && !boot_loaded_reg) begin
            boot_cnt_next = boot_cnt_reg + 1'b1;
            boot_loaded_next = (boot_cnt_reg == BOOT_CNT_W'(BOOT_WORDS - 1));
        end
        if (i_boot_irq) begin
            boot_active_next = 1'b0;
        end
        if (exec_reg != EXEC_RUN) begin
            src_next = SRC_EMU_REG;
            insn_next = emu_insn_reg;
        end else if (boot_active_reg) begin
            src_next = SRC_BOOT;
            insn_next = IDLE_OPCODE;
        end else if (i_cache_hit) begin
            src_next = SRC_CACHE;
            insn_next = i_cache_insn;
        end else begin
            src_next = SRC_MEMORY;
            insn_next = i_mem_insn;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            breakpoint_control_reg <= CTL_RESET;
            single_step_reg <= 1'b0;
            breakpoint_event_counter <= CNT_RESET;
            breakpoint_hit_status_reg <= '0;
            user_irq_reg <= 1'b0;
            addr_we_reg <= 1'b0;
            addr_idx_reg <= '0;
            addr_data_reg <= '0;
            st_valid_reg <= 1'b0;
            st_denied_reg <= 1'b0;
            st_data_reg <= '0;
            exec_reg <= EXEC_RUN;
            emu_irq_reg <= 1'b0;
            flush_reg <= 1'b0;
            boot_active_reg <= 1'b0;
            boot_cnt_reg <= '0;
            boot_loaded_reg <= 1'b0;
            src_reg <= SRC_MEMORY;
            insn_reg <= '0;
        end else begin
            breakpoint_control_reg <= breakpoint_control_next;
            single_step_reg <= single_step_next;
            breakpoint_event_counter <= counter_next;
            breakpoint_hit_status_reg <= status_next;
            user_irq_reg <= user_irq_next;
            addr_we_reg <= addr_we_next;
            addr_idx_reg <= addr_idx_next;
            addr_data_reg <= addr_data_next;
            st_valid_reg <= st_valid_next;
            st_denied_reg <= st_denied_next;
            st_data_reg <= st_data_next;
            exec_reg <= exec_next;
            emu_irq_reg <= emu_irq_next;
            flush_reg <= flush_next;
            boot_active_reg <= boot_active_next;
            boot_cnt_reg <= boot_cnt_next;
            boot_loaded_reg <= boot_loaded_next;
            src_reg <= src_next;
            insn_reg <= insn_next;
        end
    end

    assign o_breakpoint_control = breakpoint_control_reg;
    assign o_user_break_owner_bit = owner;
    assign o_addr_we = addr_we_reg;
    assign o_addr_idx = addr_idx_reg;
    assign o_addr_data = addr_data_reg;
    assign o_status_rd_valid = st_valid_reg;
    assign o_status_rd_denied = st_denied_reg;
    assign o_status_rd_data = st_data_reg;
    assign o_event_count = breakpoint_event_counter;
    assign o_user_breakpoint_irq = user_irq_reg;
    assign o_emulator_irq = emu_irq_reg;
    assign o_emu_space = (exec_reg != EXEC_RUN);
    assign o_pipe_flush = flush_reg;
    assign o_pipe_active = (src_reg != SRC_EMU_REG);
    assign o_fetch_src = src_reg;
    assign o_insn = insn_reg;
    assign o_boot_loaded = boot_loaded_reg;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);

    a_pc_sample_idle: assert property ((tap_reg == TAP_IDLE) |=>
        pc_sample_shift_reg == $past(i_pc))
        else $error("pc sample did not follow the pc in idle");
    a_tap_ctl_locked: assert property (owner && !i_sw_ctl_wr |=>
        $stable(breakpoint_control_reg))
        else $error("control changed by the tap while software owns it");
    a_addr_write_gate: assert property (i_sw_addr_wr |=> o_addr_we == $past(owner))
        else $error("address write gating wrong");
    a_status_access: assert property (i_sw_status_rd && !owner |=>
        o_status_rd_denied && o_status_rd_data == '0)
        else $error("status read allowed without ownership");
    a_status_clear: assert property (i_rti_exit && !(fire && owner) |=>
        breakpoint_hit_status_reg == '0)
        else $error("status not cleared by return");
    a_step_no_status: assert property (single_step_reg && !i_rti_exit |=>
        $stable(breakpoint_hit_status_reg))
        else $error("status updated during single step");
    a_irq_cause: assert property (o_user_breakpoint_irq |->
        $past(bp_event && owner && breakpoint_event_counter == '0))
        else $error("user breakpoint irq without a zero-count event");
    a_count_decrement: assert property (bp_event && breakpoint_event_counter != '0 &&
        !i_sw_cnt_wr |=> breakpoint_event_counter == $past(breakpoint_event_counter) - 1)
        else $error("event counter did not decrement");
    sequence s_rti_step;
        exec_reg == EXEC_HALT && single_step_reg && i_rti_exit;
    endsequence
    sequence s_flushed_step;
        o_pipe_flush && exec_reg == EXEC_STEP;
    endsequence
    a_step_entry: assert property (s_rti_step |=> s_flushed_step)
        else $error("return did not start one flushed step");
    a_step_return: assert property (exec_reg == EXEC_STEP && i_insn_retired |=>
        o_emulator_irq && o_emu_space)
        else $error("step did not return to emulation space");
    a_boot_idle: assert property (boot_active_reg && exec_reg == EXEC_RUN |=>
        o_insn == IDLE_OPCODE)
        else $error("boot did not feed idle");
    a_cache_fetch: assert property (exec_reg == EXEC_RUN && !boot_active_reg &&
        i_cache_hit |=> o_fetch_src == SRC_CACHE && o_insn == $past(i_cache_insn))
        else $error("cache hit not used");
endmodule
`default_nettype wire

// file: dv/jtag_emu.sv
// behavioural debug emulator that scans the tap pins
`timescale 1ns/1ns
`default_nettype none
module jtag_emu
    import user_break_pkg::*;
(
    output var jtag_in_s o_jtag,
    input wire logic i_tdo
);
    initial o_jtag = '0;
    // tck rests low between scans; tdi flips after each bit so no stale level lingers
    task automatic tick(input logic tms, input logic tdi, output logic tdo);
        o_jtag.tms = tms;
        o_jtag.tdi = tdi;
        // every pin change lands on a falling core clock edge, never on a sampling edge
        #200;
        tdo = i_tdo;
        o_jtag.tck = 1'b1;
        #400;
        o_jtag.tck = 1'b0;
        #100;
        o_jtag.tdi = ~tdi;
        #100;
    endtask
    // every scan ends in run-test/idle, where the pc sample keeps reloading
    task automatic scan(input logic rst, input logic [3:0] ir, input logic [47:0] dr,
                        input int len, output logic [47:0] got);
        logic t;
        got = '0;
        if (rst) for (int i = 0; i < 6; i++) tick(i < 5, 1'b0, t);
        for (int i = 0; i < 4; i++) tick(i < 2, 1'b0, t);
        for (int i = 0; i < 4; i++) tick(i == 3, ir[i], t);
        for (int i = 0; i < 5; i++) tick(i == 0 || i == 2, 1'b0, t);
        for (int i = 0; i < len; i++) tick(i == len - 1, dr[i], got[i]);
        tick(1'b1, 1'b0, t);
        tick(1'b0, 1'b0, t);
    endtask
endmodule
`default_nettype wire

// file: dv/test_user_breakpoint_and_profiling.sv
// self-checking bench for pc sampling, user breakpoints, single step and fetch selection
`timescale 1ns/1ns
`default_nettype none
module test_user_breakpoint_and_profiling
    import user_break_pkg::*;
;
    logic i_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic tdo, cw, nw, aw, sr, ret, rti, bs, bw, bi, ch, own, we, rv, rd, ui, ei, emu, fl, pa, bl;
    logic [PC_W-1:0] pc = '0;
    logic [31:0] cd = '0, nd = '0, ad = '0, ctl, adat, cnt;
    logic [3:0] hit = '0, idx = '0, aidx, rdat;
    logic [INSN_W-1:0] ci = '0, mi = '0, insn, got;
    jtag_in_s jtag;
    fetch_src_e src;
    int n_fail = 0, checks = 0, cycles = 0;
    initial {cw, nw, aw, sr, ret, rti, bs, bw, bi, ch} = '0;
    always #50 i_clk = ~i_clk;
    jtag_emu u_jtag_emu (.o_jtag(jtag), .i_tdo(tdo));
    user_breakpoint_and_profiling u_user_breakpoint_and_profiling (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .i_jtag(jtag), .o_tdo(tdo), .i_pc(pc),
        .i_sw_ctl_wr(cw), .i_sw_ctl_data(cd), .i_sw_cnt_wr(nw), .i_sw_cnt_data(nd),
        .i_sw_addr_wr(aw), .i_sw_addr_idx(idx), .i_sw_addr_data(ad), .i_sw_status_rd(sr),
        .i_group_hit(hit), .i_insn_retired(ret), .i_rti_exit(rti), .i_boot_start(bs),
        .i_boot_word(bw), .i_boot_irq(bi), .i_cache_hit(ch), .i_cache_insn(ci),
        .i_mem_insn(mi), .o_breakpoint_control(ctl), .o_user_break_owner_bit(own),
        .o_addr_we(we), .o_addr_idx(aidx), .o_addr_data(adat), .o_status_rd_valid(rv),
        .o_status_rd_denied(rd), .o_status_rd_data(rdat), .o_event_count(cnt),
        .o_user_breakpoint_irq(ui), .o_emulator_irq(ei), .o_emu_space(emu),
        .o_pipe_flush(fl), .o_pipe_active(pa), .o_fetch_src(src), .o_insn(insn),
        .o_boot_loaded(bl));
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %0t saw %h want %h", $time, seen, exp);
        end
    endtask
    // strobes rise and fall on falling edges, so one rising edge takes them
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge i_clk);
        s = 1'b0;
    endtask
    task automatic s_fetch();
        chk(own, 1'b0);
        ch = 1'b1;
        ci = 48'h1234_5678_9ABC;
        mi = 48'h0F0F_0F0F_0F0F;
        @(negedge i_clk);
        chk({src, insn}, {SRC_CACHE, ci});
        pulse(bs);
        // boot state registers first, the fetch source one cycle later
        @(negedge i_clk);
        chk({src, insn}, {SRC_BOOT, 48'h0000_0000_0000});
        repeat (BOOT_WORDS) begin
            pulse(bw);
            @(negedge i_clk);
        end
        chk({bl, src}, {1'b1, SRC_BOOT});
        pulse(bi);
        ch = 1'b0;
        @(negedge i_clk);
        @(negedge i_clk);
        chk({src, insn, pa}, {SRC_MEMORY, mi, 1'b1});
    endtask
    task automatic s_sw();
        idx = 4'h3;
        ad = 32'hDEAD_0042;
        pulse(aw);
        chk(we, 1'b0);
        pulse(sr);
        chk({rd, rv, rdat}, 6'h20);
        cd = 32'h0200_0000;
        pulse(cw); // ownership first, conditions last
        chk({own, ctl}, {1'b1, cd});
        nd = 32'h0000_0001;
        pulse(nw);
        pulse(aw);
        chk({we, aidx, adat}, {1'b1, idx, ad});
        cd = 32'h0200_0001;
        pulse(cw);
        hit = 4'h1;
        @(negedge i_clk);
        hit = 4'h0;
        chk({ui, cnt}, 33'h0);
        hit = 4'h1;
        @(negedge i_clk);
        hit = 4'h0;
        chk({ui, ei, cnt}, {2'b10, 32'h0000_0000});
        pulse(sr);
        chk({rv, rdat}, 5'h11);
        pulse(rti);
        pulse(sr);
        chk({rv, rdat}, 5'h10);
        cd = 32'h0000_0000;
        pulse(cw);
        chk(own, 1'b0);
    endtask
    task automatic s_tap();
        pc = 24'hA5_C3F1;
        u_jtag_emu.scan(1'b1, IR_PC_SAMPLE, '0, PC_W, got); // profiling before stepping
        chk(got, {24'h00_0000, pc});
        u_jtag_emu.scan(1'b0, IR_EMU_INSN, 48'hC0DE_0000_BEEF, INSN_W, got);
        u_jtag_emu.scan(1'b0, IR_BRK_CTL, 48'h0000_0000_0101, CTL_W, got);
        repeat (4) @(negedge i_clk);
        chk(ctl, 32'h0000_0101);
        hit = 4'h1;
        @(negedge i_clk);
        hit = 4'h0;
        chk({ei, emu}, 2'b11);
        @(negedge i_clk);
        chk({src, insn, pa}, {SRC_EMU_REG, 48'hC0DE_0000_BEEF, 1'b0});
        pulse(rti);
        chk(fl, 1'b1);
        pulse(ret);
        chk({ei, emu}, 2'b11);
        // software owns the unit while stepping: the irq fires, status must stay clear
        cd = 32'h0200_0001;
        pulse(cw);
        pulse(rti);
        hit = 4'h1;
        @(negedge i_clk);
        hit = 4'h0;
        chk(ui, 1'b1);
        pulse(sr);
        chk({rv, rdat}, 5'h10);
    endtask
    task automatic close_out();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            close_out();
        end
    end
    initial begin
        repeat (20) @(negedge i_clk);
        i_arst_n = 1'b1;
        @(negedge i_clk);
        s_fetch();
        s_sw();
        s_tap();
        close_out();
    end
endmodule
`default_nettype wire
